/* File: shared/cfgsl_map.svh */
`ifndef CFGSL_MAP_SVH
`define CFGSL_MAP_SVH

`define CFGSL_CLK_MHZ       50
`define CFGSL_SETTLE_NS     100
`define CFGSL_SETTLE_CYC    ((`CFGSL_SETTLE_NS * `CFGSL_CLK_MHZ + 999) / 1000)

`define CFGSL_OFF_STATUS    32'h0000_0000
`define CFGSL_OFF_RAW       32'h0000_0004
`define CFGSL_OFF_DECODED   32'h0000_0008
`define CFGSL_OFF_CTRL      32'h0000_000c

`define CFGSL_STAT_VALID    0
`define CFGSL_STAT_STATE    1
`define CFGSL_STAT_EXT      3
`define CFGSL_STAT_FREE     4
`define CFGSL_RAW_POS       0
`define CFGSL_RAW_NEG       8
`define CFGSL_RAW_FIXED     16
`define CFGSL_RAW_CHARGE    20
`define CFGSL_RAW_MODE      24
`define CFGSL_DEC_OFF       0
`define CFGSL_DEC_FIXED     8
`define CFGSL_DEC_CHARGE    16
`define CFGSL_CTRL_FREE     0
`define CFGSL_CTRL_RST      1'b0

`define CFGSL_LVL_200K_DN   3'h0
`define CFGSL_LVL_200K_UP   3'h1
`define CFGSL_LVL_10K_DN    3'h2
`define CFGSL_LVL_10K_UP    3'h3
`define CFGSL_LVL_10R_DN    3'h4
`define CFGSL_LVL_10R_UP    3'h5

`endif

/* File: shared/cfgsl_pkg.sv */
package cfgsl_pkg;
    typedef enum logic [1:0] {
        CFGSL_HOLD    = 2'h0,
        CFGSL_SETTLE  = 2'h1,
        CFGSL_CAPTURE = 2'h3,
        CFGSL_RUN     = 2'h2
    } cfgsl_state_t;
    typedef logic [5:0] cfgsl_port_mask_t;
endpackage

/* File: hdl/cfgsl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgsl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic flt_q;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    flt_q <= 1'b0;
                end else begin
                    s1_q <= d[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Only an agreed level is passed on
                    if (s2_q == s3_q) begin
                        flt_q <= s3_q;
                    end
                end
            end
            assign q[gi] = flt_q;
        end
    endgenerate
endmodule // cfgsl_sync
`default_nettype wire

/* File: hdl/cfgsl_top.sv */
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfgsl_map.svh"
module cfgsl_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ext_reset_n,
    input  wire logic [5:0]  port_pos_line_off_strap,
    input  wire logic [5:0]  port_neg_line_off_strap,
    input  wire logic [2:0]  fixed_ports_strap,
    input  wire logic [2:0]  charge_ports_strap,
    input  wire logic [2:0]  mode_strap,
    output var  logic [5:0]  port_hs_off,
    output var  logic [5:0]  port_ss_off,
    output var  logic [5:0]  fixed_ports,
    output var  logic [5:0]  charge_ports,
    output var  logic [2:0]  dev_mode,
    output var  logic        cfg_valid,
    output var  logic        pins_free,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp
);
    localparam int PW = 22;

    function automatic cfgsl_pkg::cfgsl_port_mask_t lvl_to_mask(input logic [2:0] code);
        unique case (code)
            `CFGSL_LVL_200K_DN: lvl_to_mask = 6'h00;
            `CFGSL_LVL_200K_UP: lvl_to_mask = 6'h01;
            `CFGSL_LVL_10K_DN:  lvl_to_mask = 6'h03;
            `CFGSL_LVL_10K_UP:  lvl_to_mask = 6'h07;
            `CFGSL_LVL_10R_DN:  lvl_to_mask = 6'h0f;
            `CFGSL_LVL_10R_UP:  lvl_to_mask = 6'h3f;
            // Unsupported codes fall back to the safest setting
            default:            lvl_to_mask = 6'h00;
        endcase
    endfunction

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_sync;
    logic [5:0]    pos_sync;
    logic [5:0]    neg_sync;
    logic [2:0]    fixed_sync;
    logic [2:0]    charge_sync;
    logic [2:0]    mode_sync;
    logic          ext_ok;

    assign pin_raw = {ext_reset_n, mode_strap, charge_ports_strap, fixed_ports_strap,
                      port_neg_line_off_strap, port_pos_line_off_strap};

    cfgsl_sync #(.W(PW)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pin_raw),
        .q     (pin_sync)
    );

    assign pos_sync    = pin_sync[5:0];
    assign neg_sync    = pin_sync[11:6];
    assign fixed_sync  = pin_sync[14:12];
    assign charge_sync = pin_sync[17:15];
    assign mode_sync   = pin_sync[20:18];
    assign ext_ok      = pin_sync[21];

    cfgsl_pkg::cfgsl_state_t state_q;
    logic [3:0]              settle_q;
    logic                    capture;

    assign capture = (state_q == cfgsl_pkg::CFGSL_CAPTURE);

    // Power-on release and chip-reset release both pass through settle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q  <= cfgsl_pkg::CFGSL_HOLD;
            settle_q <= 4'h0;
        end else begin
            unique case (state_q)
                cfgsl_pkg::CFGSL_HOLD: begin
                    settle_q <= 4'h0;
                    if (ext_ok) begin
                        state_q <= cfgsl_pkg::CFGSL_SETTLE;
                    end
                end
                cfgsl_pkg::CFGSL_SETTLE: begin
                    settle_q <= settle_q + 4'h1;
                    if (!ext_ok) begin
                        state_q <= cfgsl_pkg::CFGSL_HOLD;
                    end else if (settle_q == 4'(`CFGSL_SETTLE_CYC - 1)) begin
                        state_q <= cfgsl_pkg::CFGSL_CAPTURE;
                    end
                end
                cfgsl_pkg::CFGSL_CAPTURE: begin
                    state_q <= cfgsl_pkg::CFGSL_RUN;
                end
                cfgsl_pkg::CFGSL_RUN: begin
                    if (!ext_ok) begin
                        state_q <= cfgsl_pkg::CFGSL_HOLD;
                    end
                end
            endcase
        end
    end

    logic [5:0] raw_pos_q;
    logic [5:0] raw_neg_q;
    logic [2:0] raw_fixed_q;
    logic [2:0] raw_charge_q;

    // Raw levels kept for software; only changed at a capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            raw_pos_q    <= 6'h00;
            raw_neg_q    <= 6'h00;
            raw_fixed_q  <= 3'h0;
            raw_charge_q <= 3'h0;
        end else if (capture) begin
            raw_pos_q    <= pos_sync;
            raw_neg_q    <= neg_sync;
            raw_fixed_q  <= fixed_sync;
            raw_charge_q <= charge_sync;
        end
    end

    // Decoded defaults; held through later chip resets until recaptured
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_hs_off  <= 6'h00;
            port_ss_off  <= 6'h00;
            fixed_ports  <= 6'h00;
            charge_ports <= 6'h00;
            dev_mode     <= 3'h0;
            cfg_valid    <= 1'b0;
        end else if (capture) begin
            port_hs_off  <= pos_sync & neg_sync;
            port_ss_off  <= pos_sync & neg_sync;
            fixed_ports  <= lvl_to_mask(fixed_sync);
            charge_ports <= lvl_to_mask(charge_sync);
            dev_mode     <= mode_sync;
            cfg_valid    <= 1'b1;
        end
    end

    logic ctrl_free_q;
    logic wr_pend_q;
    logic [31:0] waddr_q;
    logic acc;

    assign acc = hsel && hready && htrans[1];

    // Strap pins handed to their run-time functions only after capture
    assign pins_free = ctrl_free_q && cfg_valid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc) begin
                waddr_q <= haddr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_free_q <= `CFGSL_CTRL_RST;
        end else if (wr_pend_q && waddr_q == `CFGSL_OFF_CTRL) begin
            ctrl_free_q <= hwdata[`CFGSL_CTRL_FREE];
        end
    end

    logic ctrl_view;
    logic [31:0] rd_mux;

    // Forwarding covers a read right behind a write to the same word
    assign ctrl_view = (wr_pend_q && waddr_q == `CFGSL_OFF_CTRL) ?
                       hwdata[`CFGSL_CTRL_FREE] : ctrl_free_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr)
            `CFGSL_OFF_STATUS: begin
                rd_mux[`CFGSL_STAT_VALID]                     = cfg_valid;
                rd_mux[`CFGSL_STAT_STATE +: 2]                = state_q;
                rd_mux[`CFGSL_STAT_EXT]                       = ext_ok;
                rd_mux[`CFGSL_STAT_FREE]                      = pins_free;
            end
            `CFGSL_OFF_RAW: begin
                rd_mux[`CFGSL_RAW_POS +: 6]                   = raw_pos_q;
                rd_mux[`CFGSL_RAW_NEG +: 6]                   = raw_neg_q;
                rd_mux[`CFGSL_RAW_FIXED +: 3]                 = raw_fixed_q;
                rd_mux[`CFGSL_RAW_CHARGE +: 3]                = raw_charge_q;
                rd_mux[`CFGSL_RAW_MODE +: 3]                  = dev_mode;
            end
            `CFGSL_OFF_DECODED: begin
                rd_mux[`CFGSL_DEC_OFF +: 6]                   = port_hs_off;
                rd_mux[`CFGSL_DEC_FIXED +: 6]                 = fixed_ports;
                rd_mux[`CFGSL_DEC_CHARGE +: 6]                = charge_ports;
            end
            `CFGSL_OFF_CTRL: begin
                rd_mux[`CFGSL_CTRL_FREE]                      = ctrl_view;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // Zero wait states; every access, mapped or not, answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_release_capture: assert property (
        $rose(ext_ok) && state_q != cfgsl_pkg::CFGSL_RUN |-> ##[1:8] capture)
        else $error("no capture after reset release");

    chk_reset_hold: assert property (
        state_q == cfgsl_pkg::CFGSL_RUN && !ext_ok |=> state_q == cfgsl_pkg::CFGSL_HOLD)
        else $error("chip reset not seen");

    chk_pins_free: assert property (
        pins_free |-> cfg_valid && ctrl_free_q)
        else $error("pins freed before capture");

    chk_raw_lines: assert property (
        capture |=> raw_pos_q == $past(pos_sync) && raw_neg_q == $past(neg_sync))
        else $error("line straps not captured");

    chk_port_both: assert property (
        cfg_valid |-> port_hs_off == (raw_pos_q & raw_neg_q))
        else $error("port off not both lines");

    chk_fast_follow: assert property (
        port_ss_off == port_hs_off)
        else $error("fast function not following");

    chk_fixed_decode: assert property (
        capture && fixed_sync == `CFGSL_LVL_10K_DN |=> fixed_ports == 6'h03)
        else $error("fixed ports decode wrong");

    chk_charge_decode: assert property (
        capture && charge_sync == `CFGSL_LVL_10R_UP |=> charge_ports == 6'h3f)
        else $error("charge ports decode wrong");

    chk_mode_capture: assert property (
        capture |=> dev_mode == $past(mode_sync))
        else $error("mode not captured");

    chk_hold_stable: assert property (
        !capture |=> $stable(fixed_ports) && $stable(charge_ports) && $stable(port_hs_off))
        else $error("settings changed without capture");

    cov_capture: cover property (capture);
    cov_recapture: cover property (state_q == cfgsl_pkg::CFGSL_HOLD && cfg_valid ##[1:20] capture);
    cov_ctrl_write: cover property (wr_pend_q && waddr_q == `CFGSL_OFF_CTRL);
endmodule // cfgsl_top
`default_nettype wire

/* File: bench/cfgsl_board.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgsl_board (
    input  wire logic       clk,
    input  wire logic       reuse,
    input  wire logic [5:0] pos_set,
    input  wire logic [5:0] neg_set,
    input  wire logic [8:0] lvl_set,
    output var  logic [5:0] pos,
    output var  logic [5:0] neg,
    output var  logic [8:0] lvl
);
    logic [5:0] tog_q = 6'h00;
    // Reused pins toggle so a stale capture cannot hide
    always_ff @(posedge clk) begin
        tog_q <= reuse ? tog_q + 6'h01 : 6'h00;
    end
    // Resistors hold the levels while the pins are not reused
    always_comb begin
        pos = reuse ? ~pos_set ^ tog_q : pos_set;
        neg = reuse ? ~neg_set ^ tog_q : neg_set;
        lvl = reuse ? ~lvl_set ^ {3{tog_q[2:0]}} : lvl_set;
    end
endmodule // cfgsl_board
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst_n, ext_reset_n, hsel, hwrite, hready, hreadyout, hresp;
    logic        cfg_valid, pins_free;
    logic [1:0]  htrans;
    logic [2:0]  hsize, dev_mode;
    logic [5:0]  pos_set, neg_set, pos, neg, hs_off, ss_off, fix_m, chg_m;
    logic [8:0]  lvl_set, lvl;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          error_cnt, n_tests;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cfgsl_board u_cfgsl_board (.clk(clk), .reuse(pins_free), .pos_set(pos_set),
        .neg_set(neg_set), .lvl_set(lvl_set), .pos(pos), .neg(neg), .lvl(lvl));

    cfgsl_top u_cfgsl_top (.clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .port_pos_line_off_strap(pos), .port_neg_line_off_strap(neg),
        .fixed_ports_strap(lvl[8:6]), .charge_ports_strap(lvl[5:3]), .mode_strap(lvl[2:0]),
        .port_hs_off(hs_off), .port_ss_off(ss_off), .fixed_ports(fix_m),
        .charge_ports(chg_m), .dev_mode(dev_mode), .cfg_valid(cfg_valid),
        .pins_free(pins_free), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // Every access answers OKAY with no wait state
        chk(32'({hreadyout, hresp}), 32'h0000_0002);
    endtask

    function automatic logic [5:0] mask(input logic [2:0] c);
        case (c)
            3'h1: return 6'h01;
            3'h2: return 6'h03;
            3'h3: return 6'h07;
            3'h4: return 6'h0f;
            3'h5: return 6'h3f;
            default: return 6'h00;
        endcase
    endfunction

    // Poll status until valid and running
    task automatic wait_run;
        rd = 32'h0;
        for (int k = 0; k < 40 && rd[2:0] !== 3'h5; k++) begin
            bus(1'b0, 32'h0, 32'h0);
        end
        chk({29'h0, rd[2:0]}, 32'h5);
    endtask

    task automatic outs;
        chk(32'(hs_off), 32'(pos_set & neg_set));
        chk(32'(ss_off), 32'(pos_set & neg_set));
        chk(32'(fix_m), 32'(mask(lvl_set[8:6])));
        chk(32'(chg_m), 32'(mask(lvl_set[5:3])));
        chk(32'(dev_mode), 32'(lvl_set[2:0]));
        bus(1'b0, 32'h8, 32'h0);
        chk(rd, {10'h0, mask(lvl_set[5:3]), 2'h0, mask(lvl_set[8:6]), 2'h0, pos_set & neg_set});
    endtask

    initial begin
        #200us;
        error_cnt++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        ext_reset_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pos_set = 6'h00;
        neg_set = 6'h00;
        lvl_set = 9'h000;
        error_cnt = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ext_reset_n <= 1'b0;
            pos_set <= 6'h15 ^ 6'(i);
            neg_set <= 6'h0e ^ 6'(i * 9);
            lvl_set <= {3'(i), 3'(7 - i), 3'(i + 2)};
            repeat (6) @(posedge clk);
            ext_reset_n <= 1'b1;
            wait_run();
            outs();
            bus(1'b0, 32'h4, 32'h0);
            chk(rd, {5'h0, lvl_set[2:0], 1'b0, lvl_set[5:3], 1'b0, lvl_set[8:6], 2'h0, neg_set, 2'h0, pos_set});
            bus(1'b1, 32'hc, 32'h1);
            bus(1'b0, 32'hc, 32'h0);
            chk(rd, 32'h1);
            chk(32'(pins_free), 32'h1);
            repeat (8) @(posedge clk);
            outs();
            bus(1'b1, 32'hc, 32'h0);
        end
        bus(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 32'h8, 32'hffffffff);
        outs();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'({cfg_valid, fix_m, hs_off}), 32'h0);
        rst_n <= 1'b1;
        wait_run();
        outs();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
